/* tmcm_regs.vh */
// Register offsets, field positions and reset values for the channel mode block
`ifndef TMCM_REGS_VH
`define TMCM_REGS_VH
`define TMCM_OFS_CH0 8'h00
`define TMCM_OFS_CH1 8'h04
`define TMCM_OFS_CH2 8'h08
`define TMCM_OFS_CH3 8'h0C
`define TMCM_OFS_CH4 8'h10
`define TMCM_OFS_STAT 8'h14
`define TMCM_RST_FULL 8'h C0
`define TMCM_RST_NOBUF 8'hC0
`define TMCM_FIXED_ONES 8'hC0
`define TMCM_RST_ONEHOT 11'h001
`define TMCM_BIT_BFB 5
`define TMCM_BIT_BFA 4
`define TMCM_MD_NORMAL 4'h0
`define TMCM_MD_PWM1 4'h2
`define TMCM_MD_PWM2 4'h3
`define TMCM_MD_PH1 4'h4
`define TMCM_MD_PH2 4'h5
`define TMCM_MD_PH3 4'h6
`define TMCM_MD_PH4 4'h7
`define TMCM_MD_RSPWM 4'h8
`define TMCM_MD_CPPEAK 4'hD
`define TMCM_MD_CPBOT 4'hE
`define TMCM_MD_CPBOTH 4'hF
`define TMCM_RESP_OKAY 2'b00
`define TMCM_RESP_SLVERR 2'b10
`endif

/* tmcm_decode.v */
// One channel's mode decoder: mode field to one-hot mode vector
`include "tmcm_regs.vh"
module tmcm_decode (
  input wire [3:0] mode_i,
  output reg [10:0] onehot_o,
  output wire sync_pwm_o
);
  always @* begin
    onehot_o = 11'h000;
    case (mode_i)
      `TMCM_MD_NORMAL: onehot_o[0] = 1'b1;
      `TMCM_MD_PWM1: onehot_o[1] = 1'b1;
      `TMCM_MD_PWM2: onehot_o[2] = 1'b1;
      `TMCM_MD_PH1: onehot_o[3] = 1'b1;
      `TMCM_MD_PH2: onehot_o[4] = 1'b1;
      `TMCM_MD_PH3: onehot_o[5] = 1'b1;
      `TMCM_MD_PH4: onehot_o[6] = 1'b1;
      `TMCM_MD_RSPWM: onehot_o[7] = 1'b1;
      `TMCM_MD_CPPEAK: onehot_o[8] = 1'b1;
      `TMCM_MD_CPBOT: onehot_o[9] = 1'b1;
      `TMCM_MD_CPBOTH: onehot_o[10] = 1'b1;
      // Reserved codes select nothing
      default: onehot_o = 11'h000;
    endcase
  end
  assign sync_pwm_o = |onehot_o[10:7];
endmodule // tmcm_decode

/* tmcm_mode_select.v */
// Five-channel timer mode registers with AXI4-Lite access and mode decode
// Functional notes
// - Five 8-bit read/write channel mode registers, one per channel.
// - Bits 7 and 6 reset to one, read one; software writes one.
// - Bit 5 pairs registers B and D; buffered D makes no capture/compare.
// - Bit 4 pairs registers A and C; buffered C makes no capture/compare.
// - Channels 1 and 2 buffer bits reserved, read zero; software writes zero.
// - Mode field bits 3:0 reset zero; 0000 normal, 0010 PWM1, 0011 PWM2.
// - Codes 0100 to 0111 select phase counting modes 1 to 4.
// - Code 1000 selects reset-synchronous PWM.
// - Codes 1101, 1110, 1111 select complementary PWM peak, bottom, both.
// - Channel 3 in synchronous PWM makes channel 4 follow channel 3.
`include "tmcm_regs.vh"
module tmcm_mode_select #(
  parameter NUM_CH = 5,
  parameter ADDR_W = 8
) (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire [2:0] S_AXI_AWPROT_I,
  input wire S_AXI_AWVALID_I,
  output wire S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output wire S_AXI_WREADY_O,
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire [2:0] S_AXI_ARPROT_I,
  input wire S_AXI_ARVALID_I,
  output wire S_AXI_ARREADY_O,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  output wire [NUM_CH*11-1:0] MODE_ONEHOT_O,
  output wire [NUM_CH*4-1:0] MODE_FIELD_O,
  output wire [NUM_CH-1:0] BUF_PAIR_A_EN_O,
  output wire [NUM_CH-1:0] BUF_PAIR_B_EN_O,
  output wire [NUM_CH-1:0] GEN_C_EVENT_EN_O,
  output wire [NUM_CH-1:0] GEN_D_EVENT_EN_O,
  output wire CH4_SLAVED_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data latched independently

  reg aw_held_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire do_write;
  reg [7:0] mode_reg_q [0:NUM_CH-1];
  reg wr_hit;
  reg [2:0] wr_idx;

  assign S_AXI_AWREADY_O = !aw_held_q && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_held_q && !S_AXI_BVALID_O;
  assign do_write = aw_held_q && w_held_q && !S_AXI_BVALID_O;

  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `TMCM_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held_q <= 1'b1;
        w_data_q <= S_AXI_WDATA_I;
        w_strb_q <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= wr_hit ? `TMCM_RESP_OKAY : `TMCM_RESP_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Aligned word decode; status word is read-only
  always @* begin
    wr_hit = 1'b0;
    wr_idx = 3'd0;
    case ({aw_addr_q[ADDR_W-1:2], 2'b00})
      `TMCM_OFS_CH0: begin
        wr_hit = 1'b1;
        wr_idx = 3'd0;
      end
      `TMCM_OFS_CH1: begin
        wr_hit = 1'b1;
        wr_idx = 3'd1;
      end
      `TMCM_OFS_CH2: begin
        wr_hit = 1'b1;
        wr_idx = 3'd2;
      end
      `TMCM_OFS_CH3: begin
        wr_hit = 1'b1;
        wr_idx = 3'd3;
      end
      `TMCM_OFS_CH4: begin
        wr_hit = 1'b1;
        wr_idx = 3'd4;
      end
      default: begin
        wr_hit = 1'b0;
        wr_idx = 3'd0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers and decode, one per channel

  wire [NUM_CH-1:0] sync_pwm;
  wire [NUM_CH*4-1:0] eff_mode;
  wire [NUM_CH-1:0] eff_bfa;
  wire [NUM_CH-1:0] eff_bfb;
  wire [NUM_CH-1:0] wr_en;
  wire ch4_slaved;
  reg ch4_slaved_q;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      // Channels 1 and 2 have no C or D register to pair
      localparam HAS_CD = (g != 1) && (g != 2);
      wire [7:0] wmask = HAS_CD ? 8'h3F : 8'h0F;
      wire [10:0] onehot_d;
      reg [10:0] onehot_q;
      reg [3:0] field_q;
      reg bfa_q;
      reg bfb_q;
      reg c_event_q;
      reg d_event_q;
      // Only the low byte lane carries the register
      assign wr_en[g] = do_write && wr_hit && (wr_idx == g) && w_strb_q[0];
      always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
          mode_reg_q[g] <= `TMCM_RST_NOBUF;
        end else if (wr_en[g]) begin
          // Upper bits forced, reserved buffer bits held low
          mode_reg_q[g] <= `TMCM_FIXED_ONES | (w_data_q[7:0] & wmask);
        end
      end
      // Channel 4 mirrors channel 3 while channel 3 runs synchronous PWM
      if (g == 4) begin : g_follow
        assign eff_mode[19:16] = ch4_slaved ? mode_reg_q[3][3:0]
                                 : mode_reg_q[4][3:0];
        assign eff_bfa[4] = ch4_slaved ? mode_reg_q[3][`TMCM_BIT_BFA]
                            : mode_reg_q[4][`TMCM_BIT_BFA];
        assign eff_bfb[4] = ch4_slaved ? mode_reg_q[3][`TMCM_BIT_BFB]
                            : mode_reg_q[4][`TMCM_BIT_BFB];
      end else begin : g_own
        assign eff_mode[g*4+3:g*4] = mode_reg_q[g][3:0];
        assign eff_bfa[g] = mode_reg_q[g][`TMCM_BIT_BFA];
        assign eff_bfb[g] = mode_reg_q[g][`TMCM_BIT_BFB];
      end
      tmcm_decode u_dec (
        .mode_i(eff_mode[g*4+3:g*4]),
        .onehot_o(onehot_d),
        .sync_pwm_o(sync_pwm[g])
      );
      // Registered so the counter logic never sees decode glitches
      always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
          onehot_q <= `TMCM_RST_ONEHOT;
          field_q <= `TMCM_MD_NORMAL;
          bfa_q <= 1'b0;
          bfb_q <= 1'b0;
          c_event_q <= HAS_CD ? 1'b1 : 1'b0;
          d_event_q <= HAS_CD ? 1'b1 : 1'b0;
        end else begin
          onehot_q <= onehot_d;
          field_q <= eff_mode[g*4+3:g*4];
          bfa_q <= eff_bfa[g];
          bfb_q <= eff_bfb[g];
          // A buffering register must not capture or compare
          c_event_q <= HAS_CD && !eff_bfa[g];
          d_event_q <= HAS_CD && !eff_bfb[g];
        end
      end
      assign MODE_ONEHOT_O[g*11+10:g*11] = onehot_q;
      assign MODE_FIELD_O[g*4+3:g*4] = field_q;
      assign BUF_PAIR_A_EN_O[g] = bfa_q;
      assign BUF_PAIR_B_EN_O[g] = bfb_q;
      assign GEN_C_EVENT_EN_O[g] = c_event_q;
      assign GEN_D_EVENT_EN_O[g] = d_event_q;
    end
  endgenerate

  // Software is trusted to keep channel 4 off these codes
  assign ch4_slaved = sync_pwm[3];
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ch4_slaved_q <= 1'b0;
    end else begin
      ch4_slaved_q <= ch4_slaved;
    end
  end
  assign CH4_SLAVED_O = ch4_slaved_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle answer

  reg [31:0] rd_word;
  reg rd_hit;

  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always @* begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case ({S_AXI_ARADDR_I[ADDR_W-1:2], 2'b00})
      `TMCM_OFS_CH0: rd_word = {24'h00_0000, mode_reg_q[0]};
      `TMCM_OFS_CH1: rd_word = {24'h00_0000, mode_reg_q[1]};
      `TMCM_OFS_CH2: rd_word = {24'h00_0000, mode_reg_q[2]};
      `TMCM_OFS_CH3: rd_word = {24'h00_0000, mode_reg_q[3]};
      `TMCM_OFS_CH4: rd_word = {24'h00_0000, mode_reg_q[4]};
      // Status shows effective channel 4 mode and the slaving flag
      `TMCM_OFS_STAT: rd_word = {26'h000_0000, ch4_slaved, eff_bfb[4],
                                 eff_mode[19:16]};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= `TMCM_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_word;
      S_AXI_RRESP_O <= rd_hit ? `TMCM_RESP_OKAY : `TMCM_RESP_SLVERR;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

endmodule // tmcm_mode_select

/* tmcm_mode_select_chk.sv */
// Port assertions for the channel mode block
module tmcm_mode_select_chk #(
  parameter NUM_CH = 5
) (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire S_AXI_AWREADY_O,
  input wire S_AXI_WREADY_O,
  input wire S_AXI_BVALID_O,
  input wire [1:0] S_AXI_BRESP_O,
  input wire S_AXI_ARVALID_I,
  input wire S_AXI_ARREADY_O,
  input wire S_AXI_RVALID_O,
  input wire [NUM_CH*11-1:0] MODE_ONEHOT_O,
  input wire [NUM_CH*4-1:0] MODE_FIELD_O,
  input wire [NUM_CH-1:0] BUF_PAIR_A_EN_O,
  input wire [NUM_CH-1:0] BUF_PAIR_B_EN_O,
  input wire [NUM_CH-1:0] GEN_C_EVENT_EN_O,
  input wire [NUM_CH-1:0] GEN_D_EVENT_EN_O,
  input wire CH4_SLAVED_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  AST_RST: assert property ($rose(RESET_N_I) |-> MODE_FIELD_O == 0)
    else $error("mode not cleared by reset");
  AST_NORM: assert property (MODE_ONEHOT_O[0] == (MODE_FIELD_O[3:0] == 4'h0))
    else $error("normal decode wrong");
  AST_PH: assert property (MODE_FIELD_O[7:6] == 2'b01 |-> MODE_ONEHOT_O[14+MODE_FIELD_O[5:4]])
    else $error("phase decode wrong");
  AST_SLV: assert property (CH4_SLAVED_O == (MODE_FIELD_O[15:12] inside {8, 13, 14, 15}))
    else $error("slave flag wrong");
  AST_FOLLOW: assert property (CH4_SLAVED_O |-> MODE_FIELD_O[19:16] == MODE_FIELD_O[15:12]
    && BUF_PAIR_B_EN_O[4] == BUF_PAIR_B_EN_O[3] && BUF_PAIR_A_EN_O[4] == BUF_PAIR_A_EN_O[3])
    else $error("channel 4 not following");
  AST_GENC: assert property (GEN_C_EVENT_EN_O == (~BUF_PAIR_A_EN_O & 5'h19))
    else $error("C event enable wrong");
  AST_GEND: assert property (GEN_D_EVENT_EN_O == (~BUF_PAIR_B_EN_O & 5'h19))
    else $error("D event enable wrong");
  AST_RES12: assert property (BUF_PAIR_A_EN_O[2:1] == 0 && BUF_PAIR_B_EN_O[2:1] == 0)
    else $error("reserved buffer bit set");
  AST_BPEND: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken with response pending");
  AST_RVAL: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read not answered");
  cover property (CH4_SLAVED_O);
  cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == 2'b10);
  cover property (MODE_ONEHOT_O[17]);
endmodule // tmcm_mode_select_chk
bind tmcm_mode_select tmcm_mode_select_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

/* tmcm_tb.sv */
// Self-checking bench for the channel mode block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_I = 0, RESET_N_I = 0, S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_ARVALID_I = 0;
  logic S_AXI_BREADY_I = 1, S_AXI_RREADY_I = 1;
  logic [7:0] S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0;
  logic [2:0] S_AXI_AWPROT_I = 0, S_AXI_ARPROT_I = 0;
  logic [31:0] S_AXI_WDATA_I = 0;
  logic [3:0] S_AXI_WSTRB_I = 0;
  wire S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  wire CH4_SLAVED_O;
  wire [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  wire [31:0] S_AXI_RDATA_O;
  wire [54:0] MODE_ONEHOT_O;
  wire [19:0] MODE_FIELD_O;
  wire [4:0] BUF_PAIR_A_EN_O, BUF_PAIR_B_EN_O, GEN_C_EVENT_EN_O, GEN_D_EVENT_EN_O;
  int bad_count = 0, n_tests = 0;
  int m[5] = '{default: 'hC0};
  integer seed = 32'hda9f;
  tmcm_mode_select u_tmcm_mode_select (.*);
  always #20 CLK_I = ~CLK_I;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_WSTRB_I <= s;
    S_AXI_AWVALID_I <= 1;
    S_AXI_WVALID_I <= 1;
    do begin
      @(posedge CLK_I);
      if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 0;
      if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 0;
    end while (!S_AXI_BVALID_O);
    chk(S_AXI_BRESP_O, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] v);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1;
    do begin
      @(posedge CLK_I);
      if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 0;
    end while (!S_AXI_RVALID_O);
    v = S_AXI_RDATA_O;
    chk(S_AXI_RRESP_O, r);
  endtask
  function automatic int idx(int c);
    return c < 2 ? 0 : c < 8 ? c - 1 : c == 8 ? 7 : c - 5;
  endfunction
  // Only codes that software may give each channel
  function automatic bit ok(int h, int c);
    return c == 0 || c == 2 || (c == 3 && h < 3) || (c / 4 == 1 && (h == 1 || h == 2))
      || ((c == 8 || c > 12) && h == 3);
  endfunction
  task automatic outs();
    int e;
    logic sl;
    logic [31:0] v;
    sl = m[3][3:0] inside {8, 13, 14, 15};
    for (int c = 0; c < 5; c++) begin
      e = (c == 4 && sl) ? m[3] : m[c];
      rd(8'(c * 4), 0, v);
      chk(v, m[c]);
      chk(MODE_FIELD_O[c*4+:4], e[3:0]);
      chk(MODE_ONEHOT_O[c*11+:11], 1 << idx(e[3:0]));
      chk(GEN_C_EVENT_EN_O[c], !e[4] && c != 1 && c != 2);
      chk(GEN_D_EVENT_EN_O[c], !e[5] && c != 1 && c != 2);
      chk(BUF_PAIR_A_EN_O[c], e[4]);
      chk(BUF_PAIR_B_EN_O[c], e[5]);
    end
    chk(CH4_SLAVED_O, sl);
    rd(8'h14, 0, v);
    chk(v, {sl, e[5], e[3:0]});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    integer c;
    logic [31:0] d;
    logic [3:0] s;
    repeat (16) @(posedge CLK_I);
    RESET_N_I <= 1;
    @(posedge CLK_I);
    outs();
    rd(8'h18, 2, d);
    wr(8'h18, 32'h0000_00C2, 4'hF, 2);
    wr(8'h14, 32'h0000_00C2, 4'hF, 2);
    repeat (300) begin
      c = {$random(seed)} % 5;
      do d = $random(seed); while (!ok(c, d[3:0]));
      d[7:6] = 2'b11;
      if (c == 1 || c == 2) d[5:4] = 0;
      s = $random(seed);
      wr(8'(c * 4), d, s, 0);
      if (s[0]) m[c] = d[7:0];
      outs();
    end
    // Second reset in mid-run must restore every default
    RESET_N_I <= 0;
    repeat (2) @(posedge CLK_I);
    RESET_N_I <= 1;
    m = '{default: 'hC0};
    @(posedge CLK_I);
    outs();
    conclude();
  end
  initial begin
    #2_000_000;
    bad_count++;
    conclude();
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
endmodule // tb
